// ### common/rcs_pkg.sv
// Purpose: shared constants and carriers for the reset and configuration sequencer
// Assumes: one 100 MHz clock; loaders and calibration engines sit outside
// Notes: image contents are bytes; default image value is one constant
package rcs_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int IMG_AW = 8;
	localparam int IMG_DEPTH = 256;
	localparam logic [7:0] IMG_DEFAULT = 8'h00;
	// strap field positions
	localparam int STRAP_CFG_LSB = 0;
	localparam int STRAP_CFG_W = 4;
	localparam int STRAP_SPI_BIT = 4;
	localparam int STRAP_SCAN_BIT = 5;
	localparam logic [7:0] STRAP_RESET = 8'h00;
	// eeprom probing
	localparam logic [3:0] PROBE_BASE_HI = 4'hA;
	localparam logic [2:0] PROBE_ADDR_FIRST = 3'h0;
	localparam logic [2:0] PROBE_ADDR_LAST = 3'h7;
	localparam logic [1:0] SPEED_1MHZ = 2'h0;
	localparam logic [1:0] SPEED_400KHZ = 2'h1;
	localparam logic [1:0] SPEED_100KHZ = 2'h2;
	localparam logic [15:0] EE_OFFSET_LOW = 16'h0000;
	localparam logic [15:0] EE_OFFSET_HIGH = 16'hF000;
	// serial port protocol
	localparam logic [1:0] PROTO_NONE = 2'h0;
	localparam logic [1:0] PROTO_I2C = 2'h1;
	localparam logic [1:0] PROTO_SPI4 = 2'h2;

	typedef enum logic [3:0] {
		ST_START = 4'h0,
		ST_PLL = 4'h1,
		ST_WAIT_MR = 4'h2,
		ST_DEFAULTS = 4'h3,
		ST_UPD_SCAN = 4'h4,
		ST_UPD_APPLY = 4'h5,
		ST_OTP_CFG = 4'h6,
		ST_EE_CFG = 4'h7,
		ST_HOTFIX = 4'h8,
		ST_RECAL = 4'h9,
		ST_TEMP = 4'hA,
		ST_SERIAL = 4'hB,
		ST_APPLY = 4'hC,
		ST_MONITOR = 4'hD,
		ST_ALARM = 4'hE,
		ST_RUN = 4'hF
	} rcs_state_t;

	typedef struct packed {
		logic info_load;
		logic pll_cal;
		logic upd_apply;
		logic otp_load;
		logic hotfix;
		logic temp;
	} rcs_job_t;

	typedef struct packed {
		logic req;
		logic is_update;
		logic [6:0] dev_addr;
		logic [1:0] speed;
		logic [15:0] offset;
	} rcs_probe_t;

	typedef struct packed {
		logic valid;
		logic [IMG_AW-1:0] addr;
		logic [7:0] data;
	} rcs_img_wr_t;

	typedef struct packed {
		logic upd_found;
		logic otp_ok;
		logic otp_fail;
		logic [STRAP_CFG_W-1:0] cfg_num;
		logic ee_ok;
		logic ee_fail;
		logic done;
	} rcs_status_t;
endpackage : rcs_pkg

// ### rtl/rcs_image_mem.sv
// Purpose: internal register image, one write port and one registered read port
// Assumes: single clock, write and read may hit the same word (old data read)
// Notes: array is not reset; the sequencer fills it with defaults
`timescale 1ns/100ps
`default_nettype none
module rcs_image_mem (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_we,
	input wire logic [rcs_pkg::IMG_AW-1:0] i_waddr,
	input wire logic [7:0] i_wdata,
	input wire logic [rcs_pkg::IMG_AW-1:0] i_raddr,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [rcs_pkg::IMG_DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end
endmodule : rcs_image_mem
`default_nettype wire

// ### rtl/rcs_sequencer.sv
// Purpose: reset and configuration sequencer from master reset release to normal operation
// Assumes: all pins synchronous to i_clk; engines answer with one-cycle done pulses
// Notes: straps are kept across an update restart; a new master reset release recaptures them
// Function
// - sequence starts at master reset rising edge when test select is high
// - clock output pairs stay high impedance during reset and start state
// - all general-purpose pins are inputs in the start state
// - no serial protocol selected, port silent, in the start state
// - start state loads device information block from OTP
// - PLL state then calibrates and locks the system analog PLL
// - strap levels latched at master reset rising edge and kept
// - build register image with defaults, pins and outputs unchanged
// - serial protocol from strap; SPI strap means 4-wire SPI
// - optional EEPROM update scan; found update applied then restart
// - load strap-selected OTP config; report failure or loaded number
// - OTP config writes only listed registers into the image
// - programmed PLL feedback divider starts background PLL calibration
// - serial protocol re-chosen from loaded OTP registers
// - EEPROM config search skips bad blocks, stops at first valid
// - run OTP hotfix after configuration searches
// - completion: recal, temperature, serial, apply, monitors, alarms in order
// - no EEPROM search at all when strapped to SPI
// - probe addresses 0x50..0x57 at 1 MHz, then 400 kHz, then 100 kHz
// - straps select one of 16 OTP configurations
// - config block looked for at offsets 0x0000 and 0xF000
`timescale 1ns/100ps
`default_nettype none
module rcs_sequencer (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_master_reset_n,
	input wire logic i_test_select_n,
	input wire logic [7:0] i_strap,
	output rcs_pkg::rcs_job_t o_job_req,
	input wire rcs_pkg::rcs_job_t i_job_done,
	input wire logic i_otp_ok,
	input wire logic i_otp_pll_fb_set,
	input wire logic i_otp_serial_spi,
	input wire logic i_hotfix_present,
	output rcs_pkg::rcs_probe_t o_probe,
	input wire logic i_probe_ack,
	input wire logic i_probe_present,
	input wire logic i_probe_valid,
	input wire rcs_pkg::rcs_img_wr_t i_img_wr,
	output rcs_pkg::rcs_img_wr_t o_apply,
	output logic [1:0] o_serial_proto,
	output logic o_serial_en,
	output logic o_clk_out_oe,
	output logic o_gpio_en,
	output logic o_pll_bg_cal,
	output logic o_monitor_en,
	output logic o_alarm_en,
	output rcs_pkg::rcs_status_t o_status
);
	rcs_pkg::rcs_state_t state_reg;
	rcs_pkg::rcs_state_t state_next;
	logic mr_prev_reg;
	logic armed_reg;
	logic [7:0] strap_reg;
	logic [rcs_pkg::IMG_AW:0] cnt_reg;
	logic rd_pend_reg;
	logic [rcs_pkg::IMG_AW-1:0] rd_addr_reg;
	logic [2:0] paddr_reg;
	logic [1:0] speed_reg;
	logic off_reg;
	logic any_reg;
	logic [7:0] img_rdata;
	logic mr_low;
	logic strap_spi;
	logic is_cfg;
	logic second_off;
	logic last_addr;
	logic probe_hit;
	logic probe_exhaust;
	logic cnt_last;
	logic cnt_end;
	logic img_we;

	function automatic logic is_load(input rcs_pkg::rcs_state_t s);
		is_load = (s == rcs_pkg::ST_OTP_CFG) || (s == rcs_pkg::ST_EE_CFG);
	endfunction : is_load

	function automatic logic is_search(input rcs_pkg::rcs_state_t s);
		is_search = (s == rcs_pkg::ST_UPD_SCAN) || (s == rcs_pkg::ST_EE_CFG);
	endfunction : is_search

	assign mr_low = !i_master_reset_n;
	assign strap_spi = strap_reg[rcs_pkg::STRAP_SPI_BIT];
	assign is_cfg = (state_reg == rcs_pkg::ST_EE_CFG);
	assign cnt_last = (cnt_reg == (rcs_pkg::IMG_AW+1)'(rcs_pkg::IMG_DEPTH - 1));
	assign cnt_end = (cnt_reg == (rcs_pkg::IMG_AW+1)'(rcs_pkg::IMG_DEPTH));

	// probe walk: offsets inside address inside speed
	assign last_addr = (paddr_reg == rcs_pkg::PROBE_ADDR_LAST);
	assign second_off = is_cfg && i_probe_present && !off_reg;
	assign probe_hit = i_probe_ack && i_probe_present && i_probe_valid;
	// a responding eeprom at this speed ends the search after the last address
	assign probe_exhaust = i_probe_ack && !probe_hit && !second_off && last_addr
		&& (any_reg || i_probe_present || speed_reg == rcs_pkg::SPEED_100KHZ);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			rcs_pkg::ST_START: begin
				if (i_job_done.info_load) begin
					state_next = rcs_pkg::ST_PLL;
				end
			end
			rcs_pkg::ST_PLL: begin
				if (i_job_done.pll_cal) begin
					state_next = rcs_pkg::ST_WAIT_MR;
				end
			end
			rcs_pkg::ST_WAIT_MR: begin
				if (armed_reg) begin
					state_next = rcs_pkg::ST_DEFAULTS;
				end
			end
			rcs_pkg::ST_DEFAULTS: begin
				if (cnt_last) begin
					state_next = rcs_pkg::ST_UPD_SCAN;
				end
			end
			rcs_pkg::ST_UPD_SCAN: begin
				if (strap_spi || !strap_reg[rcs_pkg::STRAP_SCAN_BIT]) begin
					state_next = rcs_pkg::ST_OTP_CFG;
				end else if (probe_hit) begin
					state_next = rcs_pkg::ST_UPD_APPLY;
				end else if (probe_exhaust) begin
					state_next = rcs_pkg::ST_OTP_CFG;
				end
			end
			rcs_pkg::ST_UPD_APPLY: begin
				if (i_job_done.upd_apply) begin
					state_next = rcs_pkg::ST_START;
				end
			end
			rcs_pkg::ST_OTP_CFG: begin
				if (i_job_done.otp_load) begin
					state_next = rcs_pkg::ST_EE_CFG;
				end
			end
			rcs_pkg::ST_EE_CFG: begin
				if (strap_spi || probe_hit || probe_exhaust) begin
					state_next = rcs_pkg::ST_HOTFIX;
				end
			end
			rcs_pkg::ST_HOTFIX: begin
				if (!i_hotfix_present || i_job_done.hotfix) begin
					state_next = rcs_pkg::ST_RECAL;
				end
			end
			rcs_pkg::ST_RECAL: begin
				if (!(o_status.otp_ok || o_status.ee_ok) || i_job_done.pll_cal) begin
					state_next = rcs_pkg::ST_TEMP;
				end
			end
			rcs_pkg::ST_TEMP: begin
				if (i_job_done.temp) begin
					state_next = rcs_pkg::ST_SERIAL;
				end
			end
			rcs_pkg::ST_SERIAL: begin
				state_next = rcs_pkg::ST_APPLY;
			end
			rcs_pkg::ST_APPLY: begin
				if (cnt_end && !rd_pend_reg) begin
					state_next = rcs_pkg::ST_MONITOR;
				end
			end
			rcs_pkg::ST_MONITOR: begin
				state_next = rcs_pkg::ST_ALARM;
			end
			rcs_pkg::ST_ALARM: begin
				state_next = rcs_pkg::ST_RUN;
			end
			rcs_pkg::ST_RUN: begin
				state_next = rcs_pkg::ST_RUN;
			end
			default: begin
				state_next = rcs_pkg::ST_START;
			end
		endcase
		// a master reset pulse restarts from the beginning in any state
		if (mr_low) begin
			state_next = rcs_pkg::ST_START;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= rcs_pkg::ST_START;
		end else begin
			state_reg <= state_next;
		end
	end

	// strap capture at the release edge; ignored while in test mode
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mr_prev_reg <= 1'b1; // pin idles high; a low start value would fake a release edge
			armed_reg <= 1'b0;
			strap_reg <= rcs_pkg::STRAP_RESET;
		end else begin
			mr_prev_reg <= i_master_reset_n;
			if (mr_low) begin
				armed_reg <= 1'b0;
			end else if (!mr_prev_reg && i_test_select_n) begin
				armed_reg <= 1'b1;
				strap_reg <= i_strap;
			end
		end
	end

	// shared counter: default fill, then image read-out
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= '0;
			rd_pend_reg <= 1'b0;
			rd_addr_reg <= '0;
		end else begin
			rd_pend_reg <= (state_reg == rcs_pkg::ST_APPLY) && !cnt_end;
			rd_addr_reg <= cnt_reg[rcs_pkg::IMG_AW-1:0];
			if (state_reg == rcs_pkg::ST_DEFAULTS) begin
				cnt_reg <= cnt_last ? '0 : cnt_reg + 1'b1;
			end else if (state_reg == rcs_pkg::ST_APPLY) begin
				if (!cnt_end) begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end else begin
				cnt_reg <= '0;
			end
		end
	end

	// loader writes land only while a configuration load is running
	assign img_we = (state_reg == rcs_pkg::ST_DEFAULTS) || (is_load(state_reg) && i_img_wr.valid);

	rcs_image_mem u_image (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_we(img_we),
		.i_waddr((state_reg == rcs_pkg::ST_DEFAULTS) ? cnt_reg[rcs_pkg::IMG_AW-1:0] : i_img_wr.addr),
		.i_wdata((state_reg == rcs_pkg::ST_DEFAULTS) ? rcs_pkg::IMG_DEFAULT : i_img_wr.data),
		.i_raddr(cnt_reg[rcs_pkg::IMG_AW-1:0]),
		.o_rdata(img_rdata)
	);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_apply <= '0;
		end else begin
			o_apply.valid <= rd_pend_reg;
			o_apply.addr <= rd_addr_reg;
			o_apply.data <= img_rdata;
		end
	end

	// eeprom probe position
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			paddr_reg <= rcs_pkg::PROBE_ADDR_FIRST;
			speed_reg <= rcs_pkg::SPEED_1MHZ;
			off_reg <= 1'b0;
			any_reg <= 1'b0;
		end else if (!is_search(state_reg) || state_next != state_reg) begin
			paddr_reg <= rcs_pkg::PROBE_ADDR_FIRST;
			speed_reg <= rcs_pkg::SPEED_1MHZ;
			off_reg <= 1'b0;
			any_reg <= 1'b0;
		end else if (i_probe_ack) begin
			if (i_probe_present) begin
				any_reg <= 1'b1;
			end
			if (second_off) begin
				off_reg <= 1'b1;
			end else begin
				off_reg <= 1'b0;
				paddr_reg <= paddr_reg + 3'h1;
				if (last_addr) begin
					speed_reg <= speed_reg + 2'h1;
				end
			end
		end
	end

	assign o_probe.req = is_search(state_reg) && !strap_spi
		&& !(state_reg == rcs_pkg::ST_UPD_SCAN && !strap_reg[rcs_pkg::STRAP_SCAN_BIT]);
	assign o_probe.is_update = (state_reg == rcs_pkg::ST_UPD_SCAN);
	assign o_probe.dev_addr = {rcs_pkg::PROBE_BASE_HI, paddr_reg};
	assign o_probe.speed = speed_reg;
	assign o_probe.offset = off_reg ? rcs_pkg::EE_OFFSET_HIGH : rcs_pkg::EE_OFFSET_LOW;

	// engine requests stay up until the matching done pulse
	always_comb begin
		o_job_req = '0;
		o_job_req.info_load = (state_reg == rcs_pkg::ST_START) && !mr_low ? 1'b1 : (state_reg == rcs_pkg::ST_START);
		o_job_req.pll_cal = (state_reg == rcs_pkg::ST_PLL)
			|| (state_reg == rcs_pkg::ST_RECAL && (o_status.otp_ok || o_status.ee_ok));
		o_job_req.upd_apply = (state_reg == rcs_pkg::ST_UPD_APPLY);
		o_job_req.otp_load = (state_reg == rcs_pkg::ST_OTP_CFG);
		o_job_req.hotfix = (state_reg == rcs_pkg::ST_HOTFIX) && i_hotfix_present;
		o_job_req.temp = (state_reg == rcs_pkg::ST_TEMP);
	end

	// result flags, cleared by a fresh master reset pulse; background calibration also drops in the PLL state
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_status <= '0;
			o_pll_bg_cal <= 1'b0;
		end else if (mr_low) begin
			o_status <= '0;
			o_pll_bg_cal <= 1'b0;
		end else begin
			if (state_reg == rcs_pkg::ST_UPD_SCAN && probe_hit) begin
				o_status.upd_found <= 1'b1;
			end
			if (state_reg == rcs_pkg::ST_OTP_CFG && i_job_done.otp_load) begin
				o_status.otp_ok <= i_otp_ok;
				o_status.otp_fail <= !i_otp_ok;
				o_status.cfg_num <= strap_reg[rcs_pkg::STRAP_CFG_LSB +: rcs_pkg::STRAP_CFG_W];
				o_pll_bg_cal <= i_otp_ok && i_otp_pll_fb_set;
			end
			if (state_reg == rcs_pkg::ST_EE_CFG && !strap_spi) begin
				if (probe_hit) begin
					o_status.ee_ok <= 1'b1;
				end else if (probe_exhaust) begin
					o_status.ee_fail <= 1'b1;
				end
			end
			if (state_reg == rcs_pkg::ST_PLL) begin
				o_pll_bg_cal <= 1'b0;
			end
			o_status.done <= (state_reg == rcs_pkg::ST_RUN);
		end
	end

	// serial port: silent at start, strap choice, then loaded choice
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_serial_proto <= rcs_pkg::PROTO_NONE;
		end else if (state_reg == rcs_pkg::ST_START || mr_low) begin
			o_serial_proto <= rcs_pkg::PROTO_NONE;
		end else if (state_reg == rcs_pkg::ST_DEFAULTS) begin
			o_serial_proto <= strap_spi ? rcs_pkg::PROTO_SPI4 : rcs_pkg::PROTO_I2C;
		end else if (state_reg == rcs_pkg::ST_OTP_CFG && i_job_done.otp_load && i_otp_ok) begin
			o_serial_proto <= i_otp_serial_spi ? rcs_pkg::PROTO_SPI4 : rcs_pkg::PROTO_I2C;
		end
	end

	// enables switch on in completion order and drop at any restart
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_serial_en <= 1'b0;
			o_clk_out_oe <= 1'b0;
			o_gpio_en <= 1'b0;
			o_monitor_en <= 1'b0;
			o_alarm_en <= 1'b0;
		end else if (mr_low || state_reg == rcs_pkg::ST_START) begin
			o_serial_en <= 1'b0;
			o_clk_out_oe <= 1'b0;
			o_gpio_en <= 1'b0;
			o_monitor_en <= 1'b0;
			o_alarm_en <= 1'b0;
		end else begin
			if (state_reg == rcs_pkg::ST_SERIAL) begin
				o_serial_en <= 1'b1;
			end
			if (state_reg == rcs_pkg::ST_APPLY && state_next == rcs_pkg::ST_MONITOR) begin
				o_clk_out_oe <= 1'b1;
				o_gpio_en <= 1'b1;
			end
			if (state_reg == rcs_pkg::ST_MONITOR) begin
				o_monitor_en <= 1'b1;
			end
			if (state_reg == rcs_pkg::ST_ALARM) begin
				o_alarm_en <= 1'b1;
			end
		end
	end
endmodule : rcs_sequencer
`default_nettype wire

// ### verification/rcs_sequencer_asserts.sv
// Purpose: port-level checks for the reset and configuration sequencer
// Assumes: one clock domain, async active-low reset
// Notes: bound to every rcs_sequencer instance
`timescale 1ns/100ps
`default_nettype none
module rcs_sequencer_asserts (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_master_reset_n,
	input wire logic i_otp_pll_fb_set,
	input wire rcs_pkg::rcs_job_t i_job_done,
	input wire rcs_pkg::rcs_job_t o_job_req,
	input wire rcs_pkg::rcs_probe_t o_probe,
	input wire rcs_pkg::rcs_img_wr_t o_apply,
	input wire logic [1:0] o_serial_proto,
	input wire logic o_serial_en,
	input wire logic o_clk_out_oe,
	input wire logic o_gpio_en,
	input wire logic o_pll_bg_cal,
	input wire logic o_monitor_en,
	input wire logic o_alarm_en,
	input wire rcs_pkg::rcs_status_t o_status
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	a_start_quiet: assert property (
		!i_master_reset_n |=> !o_clk_out_oe && !o_gpio_en && !o_serial_en && o_serial_proto == rcs_pkg::PROTO_NONE)
		else $error("outputs active after master reset");
	a_info_first: assert property (!i_master_reset_n |=> o_job_req.info_load)
		else $error("info block not requested in start state");
	a_pll_after: assert property (
		o_job_req.info_load && i_job_done.info_load && i_master_reset_n |=> o_job_req.pll_cal)
		else $error("pll calibration did not follow info load");
	a_out_order: assert property (
		$rose(o_clk_out_oe) |-> o_gpio_en && o_serial_en ##1 $rose(o_monitor_en) ##1 $rose(o_alarm_en))
		else $error("completion order wrong");
	a_serial_first: assert property ($rose(o_serial_en) |-> !o_clk_out_oe && !o_monitor_en && !o_alarm_en)
		else $error("serial port enabled late");
	a_quiet_after: assert property (o_serial_en |-> o_job_req == '0 && !o_probe.req)
		else $error("job pending after serial enable");
	a_apply_first: assert property ($rose(o_apply.valid) |-> o_apply.addr == 8'h00)
		else $error("apply does not start at word zero");
	a_apply_step: assert property (
		o_apply.valid && o_apply.addr != 8'hFF |=> o_apply.valid && o_apply.addr == $past(o_apply.addr) + 8'h01)
		else $error("apply sweep broken");
	a_done_after: assert property ($rose(o_alarm_en) |-> ##[1:2] o_status.done)
		else $error("done flag missing after alarms");
	a_probe_addr: assert property (
		o_probe.req |-> o_probe.dev_addr[6:3] == rcs_pkg::PROBE_BASE_HI && o_probe.speed <= rcs_pkg::SPEED_100KHZ)
		else $error("probe address or speed out of range");
	a_probe_offset: assert property (
		o_probe.req |-> o_probe.offset == rcs_pkg::EE_OFFSET_LOW
			|| (!o_probe.is_update && o_probe.offset == rcs_pkg::EE_OFFSET_HIGH))
		else $error("probe offset wrong");
	a_bg_cal: assert property ($rose(o_pll_bg_cal) |-> i_otp_pll_fb_set)
		else $error("background calibration without divider");
	a_upd_restart: assert property (
		o_job_req.upd_apply && i_job_done.upd_apply && i_master_reset_n |=> o_job_req.info_load)
		else $error("no restart after update");
endmodule : rcs_sequencer_asserts
bind rcs_sequencer rcs_sequencer_asserts u_chk (.i_clk, .i_rst_n, .i_master_reset_n, .i_otp_pll_fb_set,
	.i_job_done, .o_job_req, .o_probe, .o_apply, .o_serial_proto, .o_serial_en, .o_clk_out_oe,
	.o_gpio_en, .o_pll_bg_cal, .o_monitor_en, .o_alarm_en, .o_status);
`default_nettype wire

// ### verification/rcs_partner_model.sv
// Purpose: loaders, calibration engines and eeproms around the sequencer
// Assumes: requests are levels, answers one-cycle pulses after i_wait cycles
// Notes: only one eeprom, at address low bits PRES_ADDR
`timescale 1ns/100ps
`default_nettype none
module rcs_partner_model #(
	parameter logic [2:0] PRES_ADDR = 3'h2
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire rcs_pkg::rcs_job_t i_job_req,
	input wire rcs_pkg::rcs_probe_t i_probe,
	input wire logic [3:0] i_wait,
	input wire logic i_otp_ok,
	input wire logic i_present,
	input wire logic i_cfg_valid,
	input wire logic i_upd_avail,
	output rcs_pkg::rcs_job_t o_job_done,
	output logic o_probe_ack,
	output logic o_present,
	output logic o_valid,
	output rcs_pkg::rcs_img_wr_t o_img_wr
);
	logic [3:0] cnt_reg;
	logic applied_reg;
	logic busy;
	logic fire;
	logic here;
	// no new answer while the last pulse is still up
	assign busy = (|i_job_req || i_probe.req) && !(|o_job_done) && !o_probe_ack;
	assign fire = busy && cnt_reg >= i_wait;
	assign here = i_present && i_probe.dev_addr == {rcs_pkg::PROBE_BASE_HI, PRES_ADDR};
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) cnt_reg <= 4'h0;
		else cnt_reg <= (busy && !fire) ? cnt_reg + 4'h1 : 4'h0;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) applied_reg <= 1'b0;
		else if (!i_upd_avail) applied_reg <= 1'b0;
		else if (o_job_done.upd_apply) applied_reg <= 1'b1;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_job_done <= '0;
			o_probe_ack <= 1'b0;
			o_present <= 1'b0;
			o_valid <= 1'b0;
			o_img_wr <= '0;
		end else begin
			o_job_done <= fire ? i_job_req : '0;
			o_probe_ack <= fire && i_probe.req;
			o_present <= fire && here;
			// the high-offset block is always malformed here
			o_valid <= fire && here && (i_probe.is_update ? i_upd_avail && !applied_reg :
				i_cfg_valid && i_probe.offset == rcs_pkg::EE_OFFSET_LOW);
			if (i_job_req.otp_load && i_otp_ok) o_img_wr <= '{1'b1, 8'h10, 8'hA5};
			else if (fire && here && !i_probe.is_update && i_cfg_valid
				&& i_probe.offset == rcs_pkg::EE_OFFSET_LOW) o_img_wr <= '{1'b1, 8'h20, 8'h5A};
			else o_img_wr <= '0;
		end
	end
endmodule : rcs_partner_model
`default_nettype wire

// ### verification/rcs_sequencer_tb.sv
// Purpose: self-checking bench for the reset and configuration sequencer
// Assumes: partner model answers jobs and probes
// Notes: rows cover the load paths, hand tests cover resets
`timescale 1ns/100ps
`default_nettype none
module rcs_sequencer_tb;
	typedef struct packed {
		logic [7:0] strap;
		logic [6:0] cfg;
		logic [9:0] smask;
		logic [9:0] sexp;
		logic [1:0] proto;
		logic [7:0] i10;
		logic [7:0] i20;
		logic bg;
		logic [7:0] np;
		logic [7:0] ncal;
		logic [7:0] nhf;
	} rcs_row_t;
	logic i_clk, i_rst_n, mr_n, tsel_n, otp_ok, fb, ospi, hf, pres, cfgv, upd;
	logic [7:0] strap, v10, v20;
	logic [3:0] wait_n;
	rcs_pkg::rcs_job_t job_req, job_done;
	rcs_pkg::rcs_probe_t probe;
	logic ack, ppres, pval, ser_en, oe, gpio_en, bg_cal, mon_en, alm_en;
	rcs_pkg::rcs_img_wr_t img_wr, apply;
	logic [1:0] proto;
	rcs_pkg::rcs_status_t status;
	int n_mismatch = 0, comparisons = 0, napply, nz, nprobe, ncal, nhf, k;
	rcs_row_t rows [4];
	rcs_sequencer dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_master_reset_n(mr_n), .i_test_select_n(tsel_n),
		.i_strap(strap), .o_job_req(job_req), .i_job_done(job_done), .i_otp_ok(otp_ok),
		.i_otp_pll_fb_set(fb), .i_otp_serial_spi(ospi), .i_hotfix_present(hf), .o_probe(probe),
		.i_probe_ack(ack), .i_probe_present(ppres), .i_probe_valid(pval), .i_img_wr(img_wr),
		.o_apply(apply), .o_serial_proto(proto), .o_serial_en(ser_en), .o_clk_out_oe(oe),
		.o_gpio_en(gpio_en), .o_pll_bg_cal(bg_cal), .o_monitor_en(mon_en), .o_alarm_en(alm_en),
		.o_status(status));
	rcs_partner_model u_partner (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_job_req(job_req), .i_probe(probe),
		.i_wait(wait_n), .i_otp_ok(otp_ok), .i_present(pres), .i_cfg_valid(cfgv), .i_upd_avail(upd),
		.o_job_done(job_done), .o_probe_ack(ack), .o_present(ppres), .o_valid(pval), .o_img_wr(img_wr));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (!mr_n) begin
			{napply, nz, nprobe, ncal, nhf} <= '0;
			{v10, v20} <= 16'h0000;
		end else begin
			if (apply.valid) begin
				napply <= napply + 1;
				if (apply.addr == 8'h10) v10 <= apply.data;
				else if (apply.addr == 8'h20) v20 <= apply.data;
				else if (apply.data !== 8'h00) nz <= nz + 1;
			end
			if (ack) nprobe <= nprobe + 1;
			if (job_done.pll_cal) ncal <= ncal + 1;
			if (job_done.hotfix) nhf <= nhf + 1;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task pulse_mr(input logic [7:0] s);
		@(posedge i_clk) mr_n <= 1'b0;
		strap <= s;
		repeat (3) @(posedge i_clk);
		mr_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		strap <= ~s;
	endtask : pulse_mr
	task run_row(input rcs_row_t r);
		int i;
		{otp_ok, fb, ospi, hf, pres, cfgv, upd} <= r.cfg;
		pulse_mr(r.strap);
		for (i = 0; i < 20000 && status.done !== 1'b1; i++) @(posedge i_clk);
		@(posedge i_clk);
		chk(status & r.smask, r.sexp);
		chk(proto, r.proto);
		chk(v10, r.i10);
		chk(v20, r.i20);
		chk(nz, 32'h0);
		chk(napply, 32'h100);
		chk(bg_cal, r.bg);
		chk(ncal, r.ncal);
		chk(nhf, r.nhf);
		if (r.np != 8'hFF) chk(nprobe, r.np);
		chk({oe, gpio_en, ser_en, mon_en, alm_en}, 5'h1F);
	endtask : run_row
	task summarize;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize
	initial begin
		#400000;
		n_mismatch++;
		summarize;
	end
	initial begin
		i_rst_n = 1'b0;
		mr_n = 1'b0;
		tsel_n = 1'b1;
		strap = 8'h00;
		{otp_ok, fb, ospi, hf, pres, cfgv, upd} = 7'h00;
		wait_n = 4'h2;
		rows[0] = '{8'h13, 7'h78, 10'h3FD, 10'h119, 2'h2, 8'hA5, 8'h00, 1'b1, 8'h00, 8'h02, 8'h01};
		rows[1] = '{8'h27, 7'h00, 10'h387, 10'h083, 2'h1, 8'h00, 8'h00, 1'b0, 8'h30, 8'h01, 8'h00};
		// eeprom config only where otp holds none
		rows[2] = '{8'h0F, 7'h06, 10'h387, 10'h085, 2'h1, 8'h00, 8'h5A, 1'b0, 8'hFF, 8'h02, 8'h00};
		// strap picks i2c, loaded image picks spi: only the reload can give spi here
		rows[3] = '{8'h21, 7'h5D, 10'h3FF, 10'h30B, 2'h2, 8'hA5, 8'h00, 1'b0, 8'hFF, 8'h03, 8'h01};
		repeat (5) @(posedge i_clk);
		chk({oe, gpio_en, ser_en, proto}, 5'h00);
		i_rst_n <= 1'b1;
		for (k = 0; k < 4; k++) begin
			wait_n <= 4'(k + 1);
			run_row(rows[k]);
		end
		mr_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk({status, proto, oe, gpio_en, ser_en, mon_en, alm_en}, 17'h0);
		tsel_n <= 1'b0;
		pulse_mr(8'h00);
		repeat (600) @(posedge i_clk);
		chk({status.done, ser_en}, 2'b00);
		tsel_n <= 1'b1;
		wait_n <= 4'hF;
		run_row(rows[1]);
		summarize;
	end
endmodule : rcs_sequencer_tb
`default_nettype wire
